/* File: rtl/sfc_ctrl.sv */
// Self-programming flash control unit with APB register access
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module sfc_ctrl #(
  parameter int AW = 14,
  parameter int PL = 6,
  parameter bit RWW_SUPPORT = 1'b0,
  parameter logic [13:0] NO_READ_WHILE_WRITE_REGION_START_W = 14'h3800,
  // Signature row content, arbitrary value
  parameter logic [63:0] SIG_ROW = 64'h0706050403020100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gie,
  input wire logic ee_busy,
  input wire logic [AW-1:0] pc_word,
  input wire logic spm_req,
  input wire logic [15:0] z_addr,
  input wire logic [15:0] data_register_pair,
  input wire logic lpm_req,
  output logic lpm_hit,
  output logic [7:0] lpm_data,
  output logic cpu_halt,
  output logic ready_irq,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [7:0] lock_byte,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  output logic flash_start,
  output logic [1:0] flash_op,
  output logic [AW-PL-1:0] flash_page,
  input wire logic flash_done,
  input wire logic [PL-1:0] buf_idx,
  output logic [15:0] buf_data
);
  localparam int PW = 1 << PL;
  localparam logic [AW:0] FLASH_WORDS = (AW+1)'(1 << AW);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sfc_pkg::sfc_state_t st;
    logic ready_irq_enable;
    logic section_busy_flag;
    logic signature_row_read;
    logic section_read_reenable;
    logic lock_bits_access;
    logic page_write_cmd;
    logic page_erase_cmd;
    logic store_program_enable;
    logic [2:0] age;
    logic fill_act;
    logic [PW-1:0][15:0] pbuf;
    logic [31:0] prdata;
    logic lpm_hit;
    logic [7:0] lpm_data;
    logic fstart;
    logic [1:0] fop;
    logic [AW-PL-1:0] fpage;
    logic irq;
    logic [15:0] bdata;
  } sfc_regs_t;

  sfc_regs_t r_r;
  sfc_regs_t r_nxt;
  logic [AW:0] boundary_w;
  logic [AW-1:0] tgt_w;
  logic in_boot;
  logic tgt_boot;
  logic spm_win;
  logic lpm_win;
  logic wr_locked;
  logic ctrl_wr;
  logic fill_go;
  logic lpm_go;

  function automatic sfc_regs_t disarm(input sfc_regs_t x);
    sfc_regs_t y;
    y = x;
    y.st = sfc_pkg::SFC_IDLE;
    y.signature_row_read = 1'b0;
    y.section_read_reenable = 1'b0;
    y.lock_bits_access = 1'b0;
    y.page_write_cmd = 1'b0;
    y.page_erase_cmd = 1'b0;
    y.store_program_enable = 1'b0;
    y.age = 3'h0;
    return y;
  endfunction

  // ****************************************************************
  // Section decode
  // ****************************************************************
  // boundary from fuses
  assign boundary_w = FLASH_WORDS -
    (AW+1)'(sfc_pkg::BOOT_WORDS[boot_size_fuses]);
  assign tgt_w = z_addr[AW:1];
  assign in_boot = {1'b0, pc_word} >= boundary_w;
  assign tgt_boot = {1'b0, tgt_w} >= boundary_w;
  assign wr_locked = tgt_boot ? !lock_byte[sfc_pkg::POS_BOOT_WR_LOCK]
                              : !lock_byte[sfc_pkg::POS_APP_WR_LOCK];
  // age zero is the first cycle after the write
  assign spm_win = (r_r.st == sfc_pkg::SFC_ARMED) &&
                   (r_r.age < sfc_pkg::SPM_WIN_CYC);
  assign lpm_win = (r_r.st == sfc_pkg::SFC_ARMED) &&
                   (r_r.age < sfc_pkg::LPM_WIN_CYC);
  assign ctrl_wr = psel && penable && pwrite && (paddr == sfc_pkg::CTRL_OFS);
  assign fill_go = spm_req && spm_win && in_boot &&
                   !r_r.signature_row_read && !r_r.page_write_cmd &&
                   !r_r.page_erase_cmd && !r_r.section_read_reenable &&
                   !r_r.lock_bits_access;
  assign lpm_go = !spm_req && lpm_req && lpm_win &&
                  (r_r.lock_bits_access || r_r.signature_row_read);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_nxt = r_r;
    r_nxt.fstart = 1'b0;
    r_nxt.lpm_hit = 1'b0;
    unique case (r_r.st)
      sfc_pkg::SFC_IDLE: begin
        r_nxt.age = 3'h0;
      end
      sfc_pkg::SFC_ARMED: begin
        if (spm_req) begin
          r_nxt = disarm(r_nxt);
          if (!spm_win || !in_boot || r_r.signature_row_read) begin
            // store after signature arming is dropped
            r_nxt = disarm(r_nxt);
          end else if (r_r.page_write_cmd || r_r.page_erase_cmd) begin
            // page erase or page write of the pointer page
            // boot code may target either section
            if (!wr_locked) begin
              r_nxt.st = sfc_pkg::SFC_BUSY;
              r_nxt.fstart = 1'b1;
              r_nxt.fop = r_r.page_write_cmd ? sfc_pkg::FOP_WRITE
                                             : sfc_pkg::FOP_ERASE;
              r_nxt.fpage = z_addr[AW:PL+1];
              r_nxt.store_program_enable = 1'b1;
              r_nxt.page_write_cmd = r_r.page_write_cmd;
              r_nxt.page_erase_cmd = r_r.page_erase_cmd;
              // busy while read-while-write area is blocked
              r_nxt.section_busy_flag = RWW_SUPPORT &&
                                        (tgt_w < NO_READ_WHILE_WRITE_REGION_START_W);
            end
          end else if (r_r.section_read_reenable) begin
            r_nxt.section_busy_flag = 1'b0;
          end else if (!r_r.lock_bits_access) begin
            // fill one buffer word, pointer bit zero ignored
            r_nxt.pbuf[z_addr[PL:1]] = data_register_pair;
            r_nxt.fill_act = 1'b1;
          end
        end else if (lpm_go) begin
          r_nxt = disarm(r_nxt);
          r_nxt.lpm_hit = 1'b1;
          if (r_r.signature_row_read) begin
            r_nxt.lpm_data = SIG_ROW[{z_addr[2:0], 3'h0} +: 8];
          end else begin
            // lock or fuse by pointer low bits
            // bytes pass as stored, zero means programmed
            unique case (z_addr[1:0])
              sfc_pkg::ADDR_FUSE_LOW: r_nxt.lpm_data = fuse_low;
              sfc_pkg::ADDR_LOCK: r_nxt.lpm_data = lock_byte;
              sfc_pkg::ADDR_FUSE_EXT: r_nxt.lpm_data = fuse_ext;
              sfc_pkg::ADDR_FUSE_HIGH: r_nxt.lpm_data = fuse_high;
            endcase
          end
        end else if (r_r.age == sfc_pkg::SPM_WIN_CYC - 3'h1) begin
          r_nxt = disarm(r_nxt);
        end else begin
          r_nxt.age = r_r.age + 3'h1;
        end
      end
      sfc_pkg::SFC_BUSY: begin
        if (flash_done) begin
          r_nxt = disarm(r_nxt);
          r_nxt.fop = sfc_pkg::FOP_NONE;
          if (r_r.page_write_cmd) begin
            r_nxt.pbuf = '0;
            r_nxt.fill_act = 1'b0;
          end
        end
      end
      default: begin
        r_nxt = disarm(r_nxt);
      end
    endcase

    // APB control write; commands only accepted when idle
    if (ctrl_wr) begin
      r_nxt.ready_irq_enable = pwdata[sfc_pkg::POS_READY_IRQ_ENABLE];
      // EEPROM write blocks any new command
      if (r_r.st == sfc_pkg::SFC_IDLE && !ee_busy) begin
        unique case (pwdata[4:0])
          sfc_pkg::CMD_FILL, sfc_pkg::CMD_ERASE, sfc_pkg::CMD_WRITE,
          sfc_pkg::CMD_LOCK, sfc_pkg::CMD_REENABLE: begin
            r_nxt.st = sfc_pkg::SFC_ARMED;
            r_nxt.age = 3'h0;
            r_nxt.store_program_enable = 1'b1;
            r_nxt.page_erase_cmd = pwdata[sfc_pkg::POS_PAGE_ERASE_CMD];
            r_nxt.page_write_cmd = pwdata[sfc_pkg::POS_PAGE_WRITE_CMD];
            r_nxt.lock_bits_access = pwdata[sfc_pkg::POS_LOCK_BITS_ACCESS];
            r_nxt.section_read_reenable =
              pwdata[sfc_pkg::POS_SECTION_READ_REENABLE];
            r_nxt.signature_row_read = (pwdata[4:0] == sfc_pkg::CMD_FILL) &&
              pwdata[sfc_pkg::POS_SIGNATURE_ROW_READ];
            // re-enable during fill loses the buffer
            if (pwdata[sfc_pkg::POS_SECTION_READ_REENABLE] && r_r.fill_act)
            begin
              r_nxt.pbuf = '0;
              r_nxt.fill_act = 1'b0;
            end
          end
          default: begin
            r_nxt.st = r_r.st;
          end
        endcase
      end
    end

    // Read data captured in the setup phase
    if (psel && !penable) begin
      unique case (paddr)
        sfc_pkg::CTRL_OFS: r_nxt.prdata = {24'h0, r_r.ready_irq_enable,
          r_r.section_busy_flag, r_r.signature_row_read,
          r_r.section_read_reenable, r_r.lock_bits_access,
          r_r.page_write_cmd, r_r.page_erase_cmd, r_r.store_program_enable};
        sfc_pkg::STAT_OFS: r_nxt.prdata = {29'h0, in_boot, r_r.fill_act,
          r_r.st == sfc_pkg::SFC_BUSY};
        default: r_nxt.prdata = 32'h0;
      endcase
    end
    if (!RWW_SUPPORT) begin
      r_nxt.section_busy_flag = 1'b0;
    end
    // ready request while store enable is clear
    // masked by EEPROM write and active operation
    r_nxt.irq = r_r.ready_irq_enable && gie && !r_r.store_program_enable &&
                !ee_busy && (r_r.st != sfc_pkg::SFC_BUSY);
    r_nxt.bdata = r_r.pbuf[buf_idx];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
      r_r.st <= sfc_pkg::SFC_IDLE;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero wait states; a frozen block holds the bus instead
  assign pready = ce;
  assign pslverr = psel && penable && (paddr != sfc_pkg::CTRL_OFS) &&
                   (paddr != sfc_pkg::STAT_OFS);
  assign prdata = r_r.prdata;
  assign lpm_hit = r_r.lpm_hit;
  assign lpm_data = r_r.lpm_data;
  // stall for whole erase or write
  assign cpu_halt = (r_r.st == sfc_pkg::SFC_BUSY);
  assign ready_irq = r_r.irq;
  assign flash_start = r_r.fstart;
  assign flash_op = r_r.fop;
  assign flash_page = r_r.fpage;
  assign buf_data = r_r.bdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_irq_on;
    @(posedge pclk) disable iff (!presetn)
    ce && r_r.ready_irq_enable && gie && !r_r.store_program_enable &&
    !ee_busy && !cpu_halt |=> ready_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
    ce && (ee_busy || cpu_halt) |=> !ready_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq leak");

  property p_busy_zero;
    @(posedge pclk) disable iff (!presetn)
    !RWW_SUPPORT |-> !r_r.section_busy_flag;
  endproperty
  a_busy_zero: assert property (p_busy_zero) else $error("busy set");

  property p_late_spm;
    @(posedge pclk) disable iff (!presetn)
    ce && spm_req && !spm_win |=> !flash_start;
  endproperty
  a_late_spm: assert property (p_late_spm) else $error("late store");

  property p_app_spm;
    @(posedge pclk) disable iff (!presetn)
    ce && spm_req && !in_boot && !cpu_halt |=> !flash_start && !cpu_halt;
  endproperty
  a_app_spm: assert property (p_app_spm) else $error("app store");

  property p_sig_spm;
    @(posedge pclk) disable iff (!presetn)
    ce && spm_req && r_r.signature_row_read |=> !flash_start;
  endproperty
  a_sig_spm: assert property (p_sig_spm) else $error("sig store");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
    ce && spm_win && ctrl_wr == 1'b0 && !spm_req && !lpm_go &&
    r_r.age == 3'h3 |=> !r_r.store_program_enable && !r_r.page_write_cmd
    && !r_r.page_erase_cmd;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no timeout");

  property p_hold_busy;
    @(posedge pclk) disable iff (!presetn)
    flash_start ##0 (!flash_done [*3]) |-> cpu_halt &&
    r_r.store_program_enable;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("no hold");

  property p_lock_read;
    @(posedge pclk) disable iff (!presetn)
    ce && lpm_go && r_r.lock_bits_access && z_addr[1:0] == 2'h1
    |=> lpm_hit && lpm_data == $past(lock_byte);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read");

  property p_bad_cmd;
    @(posedge pclk) disable iff (!presetn)
    ce && ctrl_wr && !cpu_halt && !spm_win && pwdata[4:0] == 5'h07
    |=> !r_r.store_program_enable;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad cmd");

  property p_fill;
    @(posedge pclk) disable iff (!presetn)
    ce && fill_go |=> r_r.fill_act && !r_r.store_program_enable;
  endproperty
  a_fill: assert property (p_fill) else $error("fill lost");

  c_fill: cover property (@(posedge pclk) ce && fill_go);
  c_start: cover property (@(posedge pclk) flash_start);
  c_lpm: cover property (@(posedge pclk) lpm_hit);
  c_done: cover property (@(posedge pclk) cpu_halt && flash_done);
endmodule

/* File: rtl/sfc_pkg.sv */
// Constants and types of the self-programming flash controller
package sfc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control byte field positions
  localparam int POS_READY_IRQ_ENABLE = 7;
  localparam int POS_SECTION_BUSY_FLAG = 6;
  localparam int POS_SIGNATURE_ROW_READ = 5;
  localparam int POS_SECTION_READ_REENABLE = 4;
  localparam int POS_LOCK_BITS_ACCESS = 3;
  localparam int POS_PAGE_WRITE_CMD = 2;
  localparam int POS_PAGE_ERASE_CMD = 1;
  localparam int POS_STORE_PROGRAM_ENABLE = 0;
  // Status register field positions
  localparam int POS_OP_BUSY = 0;
  localparam int POS_FILL_ACTIVE = 1;
  localparam int POS_EXEC_IN_BOOT = 2;
  // ****************************************************************
  // Permitted patterns of the low five control bits
  // ****************************************************************
  localparam logic [4:0] CMD_FILL = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  // ****************************************************************
  // Arming windows in clock cycles
  // ****************************************************************
  localparam logic [2:0] SPM_WIN_CYC = 3'h4;
  localparam logic [2:0] LPM_WIN_CYC = 3'h3;
  // Pointer low bits selecting the protection and configuration bytes
  localparam logic [1:0] ADDR_FUSE_LOW = 2'h0;
  localparam logic [1:0] ADDR_LOCK = 2'h1;
  localparam logic [1:0] ADDR_FUSE_EXT = 2'h2;
  localparam logic [1:0] ADDR_FUSE_HIGH = 2'h3;
  // Lock byte: write-protect bits of each section, zero = programmed
  localparam int POS_APP_WR_LOCK = 2;
  localparam int POS_BOOT_WR_LOCK = 4;
  // Boot section size in words, indexed by the boot size fuses
  localparam logic [3:0][15:0] BOOT_WORDS = {
    16'h0100, 16'h0200, 16'h0400, 16'h0800};
  // Flash operation codes
  localparam logic [1:0] FOP_NONE = 2'h0;
  localparam logic [1:0] FOP_ERASE = 2'h1;
  localparam logic [1:0] FOP_WRITE = 2'h2;
  typedef enum logic [2:0] {
    SFC_IDLE = 3'h1,
    SFC_ARMED = 3'h2,
    SFC_BUSY = 3'h4
  } sfc_state_t;
endpackage

/* File: test/sfc_flash_model.sv */
// Flash macro model answering start pulses with a done pulse
`timescale 1ns/100ps
module sfc_flash_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flash_start,
  input wire logic slow,
  output logic flash_done
);
  // ****************************************************************
  // Operation timing
  // ****************************************************************
  logic [5:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt_r == 6'h01);
      if (flash_start) begin
        // Slow answer keeps the core halted long enough to poll
        cnt_r <= slow ? 6'h14 : 6'h02;
      end else if (cnt_r != 6'h00) begin
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end
endmodule

/* File: test/testbench.sv */
// Self-checking bench of the self-programming flash controller
`timescale 1ns/100ps
module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, gie;
  logic ee_busy, spm_req, lpm_req, lpm_hit, cpu_halt, ready_irq, slow;
  logic flash_start, flash_done;
  logic [7:0] paddr, lpm_data, lock_byte, fuse_low, fuse_high, fuse_ext;
  logic [7:0] v, flash_page;
  logic [31:0] pwdata, prdata;
  logic [13:0] pc_word;
  logic [15:0] z_addr, dpair, buf_data;
  logic [1:0] bsf, flash_op;
  logic [5:0] buf_idx;
  logic [64:0] me;
  logic [64:0] rd_q[$];
  logic [9:0] fl_q[$];
  logic [7:0] lp_q[$];
  logic [4:0] cmds [4];
  int fail_count, n_checks, seed, i;
  localparam logic [13:0] BPC = 14'h3F10;
  // Signature value arbitrary
  localparam logic [63:0] SIG = 64'h1122334455667788;
  sfc_ctrl #(.SIG_ROW(SIG)) dut_u (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gie(gie), .ee_busy(ee_busy), .pc_word(pc_word),
    .spm_req(spm_req), .z_addr(z_addr), .data_register_pair(dpair),
    .lpm_req(lpm_req), .lpm_hit(lpm_hit), .lpm_data(lpm_data),
    .cpu_halt(cpu_halt), .ready_irq(ready_irq), .boot_size_fuses(bsf),
    .lock_byte(lock_byte), .fuse_low(fuse_low), .fuse_high(fuse_high),
    .fuse_ext(fuse_ext), .flash_start(flash_start), .flash_op(flash_op),
    .flash_page(flash_page), .flash_done(flash_done), .buf_idx(buf_idx),
    .buf_data(buf_data));
  sfc_flash_model fm_u (.pclk(pclk), .presetn(presetn),
    .flash_start(flash_start), .slow(slow), .flash_done(flash_done));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ****************************************************************
  // Compare tasks
  // ****************************************************************
  task report(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_rd(input logic [64:0] e);
    report(prdata & e[63:32], e[31:0] & e[63:32]);
    report({31'h0, pslverr}, {31'h0, e[64]});
  endtask
  task chk_lp(input logic [7:0] e);
    report({24'h0, lpm_data}, {24'h0, e});
  endtask
  task chk_fl(input logic [9:0] e);
    report({22'h0, flash_op, flash_page}, {22'h0, e});
  endtask
  task chk_lvl(input logic [15:0] g, input logic [15:0] e);
    report({16'h0, g}, {16'h0, e});
  endtask
  // Unexpected results meet an unknown note and fail
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      me = rd_q.size() ? rd_q.pop_front() : {1'b0, 32'hFFFFFFFF, 32'hX};
      chk_rd(me);
    end
    if (lpm_hit) chk_lp(lp_q.size() ? lp_q.pop_front() : 8'hXX);
    if (flash_start) chk_fl(fl_q.size() ? fl_q.pop_front() : 10'hXXX);
  end
  // ****************************************************************
  // Drivers
  // ****************************************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wrc(input logic [7:0] c);
    apb(1'b1, sfc_pkg::CTRL_OFS, {24'h0, c | 8'h80});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({a > sfc_pkg::STAT_OFS, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task core(input int d, input logic s, input logic [13:0] pc,
            input logic [15:0] z);
    repeat (d - 1) @(posedge pclk);
    spm_req <= s;
    lpm_req <= !s;
    pc_word <= pc;
    z_addr <= z;
    dpair <= 16'($random(seed));
    @(posedge pclk);
    spm_req <= 1'b0;
    lpm_req <= 1'b0;
  endtask
  task wait_idle;
    repeat (2) @(negedge pclk);
    for (i = 0; i < 200 && cpu_halt !== 1'b0; i++) @(negedge pclk);
    if (i == 200) report(32'h1, 32'h0);
    @(posedge pclk);
  endtask
  task op(input logic [7:0] c, input logic [13:0] pc, input logic [15:0] z,
          input int d, input logic ok, input logic [7:0] lk,
          input logic [1:0] fz, input logic sl);
    lock_byte <= lk;
    bsf <= fz;
    slow <= sl;
    wrc(c);
    if (ok) fl_q.push_back({c[2] ? sfc_pkg::FOP_WRITE : sfc_pkg::FOP_ERASE,
                            z[14:7]});
    core(d, 1'b1, pc, z);
    repeat (2) @(negedge pclk);
    chk_lvl(cpu_halt, ok);
    chk_lvl(ready_irq, !ok);
    if (ok && sl) rd(sfc_pkg::CTRL_OFS, c | 8'h80, 32'hFF);
    wait_idle;
    rd(sfc_pkg::CTRL_OFS, 32'h80, 32'hFFFFFFFF);
    chk_lvl(ready_irq, 1'b1);
  endtask
  task ld(input logic [7:0] c, input logic [15:0] z, input int d,
          input logic hit, input logic [7:0] e);
    wrc(c);
    if (hit) lp_q.push_back(e);
    core(d, 1'b0, BPC, z);
    rd(sfc_pkg::CTRL_OFS, 32'h80, 32'hFFFFFFFF);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    complete_run;
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    seed = 32'hb57926ea;
    {ce, presetn, psel, penable, pwrite, gie, ee_busy} = 7'h40;
    {spm_req, lpm_req, slow, paddr, pwdata, pc_word, z_addr} = '0;
    {dpair, buf_idx, bsf, lock_byte} = {22'h0, 2'h3, 8'hFF};
    {fuse_low, fuse_high, fuse_ext} = 24'($random(seed));
    cmds = '{sfc_pkg::CMD_FILL, sfc_pkg::CMD_ERASE, sfc_pkg::CMD_WRITE,
             sfc_pkg::CMD_LOCK};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(sfc_pkg::CTRL_OFS, sfc_pkg::CTRL_RESET, 32'hFFFFFFFF);
    rd(sfc_pkg::STAT_OFS, 32'h0, 32'h3);
    rd(8'h08, 32'h0, 32'hFFFFFFFF);
    for (int k = 0; k < 8; k++) begin
      v = 8'($random(seed)) & 8'h1F;
      if (v[4:0] inside {sfc_pkg::CMD_FILL, sfc_pkg::CMD_ERASE,
          sfc_pkg::CMD_WRITE, sfc_pkg::CMD_LOCK, sfc_pkg::CMD_REENABLE})
        v = 8'h1F;
      apb(1'b1, sfc_pkg::CTRL_OFS, {24'h0, v});
      rd(sfc_pkg::CTRL_OFS, 32'h0, 32'hFFFFFFFF);
    end
    gie <= 1'b1;
    wrc(8'h00);
    repeat (3) @(posedge pclk);
    chk_lvl(ready_irq, 1'b1);
    ee_busy <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_lvl(ready_irq, 1'b0);
    ee_busy <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wrc({3'h0, cmds[k]});
      rd(sfc_pkg::CTRL_OFS, {24'h0, 3'h4, cmds[k]}, 32'hFF);
      repeat (3) @(posedge pclk);
      rd(sfc_pkg::CTRL_OFS, 32'h80, 32'hFF);
    end
    wrc(sfc_pkg::CMD_FILL);
    core(1, 1'b1, BPC, 16'h0013);
    v = 8'h00;
    buf_idx <= 6'h09;
    repeat (3) @(negedge pclk);
    chk_lvl(buf_data, dpair);
    rd(sfc_pkg::STAT_OFS, 32'h6, 32'h7);
    wrc(sfc_pkg::CMD_REENABLE);
    rd(sfc_pkg::STAT_OFS, 32'h0, 32'h2);
    repeat (4) @(posedge pclk);
    op(8'h03, BPC, 16'h7F80, 4, 1'b1, 8'hFF, 2'h3, 1'b1);
    op(8'h05, BPC, 16'h0100, 1, 1'b1, 8'hFF, 2'h3, 1'b0);
    op(8'h03, BPC, 16'h0100, 5, 1'b0, 8'hFF, 2'h3, 1'b0);
    op(8'h03, 14'h3900, 16'h0100, 1, 1'b0, 8'hFF, 2'h3, 1'b0);
    op(8'h05, 14'h3900, 16'h0100, 2, 1'b1, 8'hFF, 2'h0, 1'b1);
    op(8'h03, BPC, 16'h0100, 1, 1'b0, 8'hFB, 2'h3, 1'b0);
    op(8'h03, BPC, 16'h7F80, 1, 1'b0, 8'hEF, 2'h3, 1'b0);
    op(8'h03, BPC, 16'h7F80, 3, 1'b1, 8'hFB, 2'h3, 1'b0);
    op(8'h21, BPC, 16'h0100, 1, 1'b0, 8'hFF, 2'h3, 1'b0);
    ld(8'h09, 16'h0000, 1, 1'b1, fuse_low);
    ld(8'h09, 16'h0001, 2, 1'b1, lock_byte);
    ld(8'h09, 16'h0002, 3, 1'b1, fuse_ext);
    ld(8'h09, 16'h0003, 1, 1'b1, fuse_high);
    ld(8'h09, 16'h0001, 4, 1'b0, 8'h00);
    ld(8'h21, 16'h0003, 2, 1'b1, SIG[31:24]);
    repeat (4) @(posedge pclk);
    if (rd_q.size() || lp_q.size() || fl_q.size()) report(32'h1, 32'h0);
    complete_run;
  end
endmodule
